//--- rtl/usd_uart.sv
// usd_uart: serial port status, data and baud logic with transmit and receive
`timescale 1ns/1ps

// How it works
// - tx_empty: holding and shift both empty
// - tx_holding_empty shows holding register vacancy
// - holding empty raises irq or dma
// - holding write clears tx_holding_empty
// - tx_holding_empty ignores status writes
// - rx_ready set on data, raises request
// - receive buffer read clears rx_ready
// - status bit 4 mirrors dtr pin
// - break sets break_seen, status irq
// - framing error sets frame_err, status irq
// - parity failure sets parity_err, status irq
// - overrun sets overrun_err, status irq
// - transmit copies holding into shift register
// - receive shifts next frame while buffered
// - 16x clock, baud = f/(div+1)/32
// - reset forces both modes to off
// - tx_mode off resets transmitter, line high unless brk set
// - rx_mode off resets receiver
// - status irq needs enable and error
// - word length 5..8, right justified
module usd_uart (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire usd_pkg::usd_req_s busReq,
   output logic [31:0] rdData,
   input wire logic rxd,
   output logic txd,
   input wire logic dtr,
   output logic dsr,
   output logic txIrq,
   output logic rxIrq,
   output logic rxStatusIrq,
   output logic [1:0] txDmaReq,
   output logic [1:0] rxDmaReq
);
   import usd_pkg::*;

   usd_state_s s;
   usd_state_s next_s;
   logic txEmpty;
   logic rxIn;
   logic rxBufRead;
   logic txLoad;

   function automatic logic [2:0] lastBit(input logic [1:0] wl);
      lastBit = 3'(3'h4 + {1'b0, wl});
   endfunction

   function automatic logic [7:0] justify(input logic [7:0] d, input logic [1:0] wl);
      justify = d >> (2'h3 - wl);
   endfunction

   function automatic logic parityOf(input logic [7:0] d, input logic [2:0] pm);
      case (pm)
         USD_PAR_ODD: parityOf = ~^d;
         USD_PAR_EVEN: parityOf = ^d;
         USD_PAR_ONE: parityOf = 1'b1;
         default: parityOf = 1'b0;
      endcase
   endfunction

   assign txEmpty = !s.txHoldFull && (s.txSt == TX_IDLE);
   assign rxIn = s.loop ? !s.txLineLow : rxd;
   assign txd = s.loop ? 1'b1 : !s.txLineLow;
   assign dsr = s.dsr;
   assign rdData = s.rdData;
   assign txIrq = !s.txHoldFull && (s.txMode == USD_MODE_IRQ);
   assign txDmaReq[0] = !s.txHoldFull && (s.txMode == USD_MODE_DMA0);
   assign txDmaReq[1] = !s.txHoldFull && (s.txMode == USD_MODE_DMA1);
   assign rxIrq = s.rxReady && (s.rxMode == USD_MODE_IRQ);
   assign rxDmaReq[0] = s.rxReady && (s.rxMode == USD_MODE_DMA0);
   assign rxDmaReq[1] = s.rxReady && (s.rxMode == USD_MODE_DMA1);
   assign rxStatusIrq = s.rx_status_irq_en && (s.breakSeen || s.frameErr || s.parityErr || s.overrunErr);
   assign rxBufRead = busReq.rd && (busReq.addr == USD_ADDR_RX_BUFFER);
   // load on a tick only, so the start bit spans full 16 ticks
   assign txLoad = (s.txMode != USD_MODE_OFF) && (s.txSt == TX_IDLE) && s.txHoldFull && s.tick;

   always_comb begin
      next_s = s;
      next_s.rdData = '0;
      // baud divider: phase flips every div+1 cycles, tick once per full period
      next_s.tick = 1'b0;
      if (s.divCnt >= s.baud_divisor) begin
         next_s.divCnt = '0;
         next_s.phase = !s.phase;
         next_s.tick = s.phase;
      end else begin
         next_s.divCnt = USD_DIV_W'(s.divCnt + 1'b1);
      end

      // register reads
      if (busReq.rd) begin
         case (busReq.addr)
            USD_ADDR_CTRL: begin
               next_s.rdData[USD_CT_LOOP] = s.loop;
               next_s.rdData[USD_CT_BRK] = s.brk;
               next_s.rdData[USD_CT_DSR] = s.dsr;
               next_s.rdData[USD_CT_PMODE_LO +: 3] = s.pmode;
               next_s.rdData[USD_CT_STOP] = s.stop2;
               next_s.rdData[USD_CT_WLEN_LO +: 2] = s.wordLen;
               next_s.rdData[USD_CT_TX_MODE_LO +: 2] = s.txMode;
               next_s.rdData[USD_CT_RX_STATUS_IRQ_EN] = s.rx_status_irq_en;
               next_s.rdData[USD_CT_RX_MODE_LO +: 2] = s.rxMode;
            end
            USD_ADDR_STATUS: begin
               next_s.rdData[USD_ST_TX_EMPTY] = txEmpty;
               next_s.rdData[USD_ST_TX_HOLD_EMPTY] = !s.txHoldFull;
               next_s.rdData[USD_ST_RX_READY] = s.rxReady;
               next_s.rdData[USD_ST_DTR] = dtr;
               next_s.rdData[USD_ST_BREAK] = s.breakSeen;
               next_s.rdData[USD_ST_FRAME] = s.frameErr;
               next_s.rdData[USD_ST_PARITY] = s.parityErr;
               next_s.rdData[USD_ST_OVERRUN] = s.overrunErr;
            end
            USD_ADDR_RX_BUFFER: begin
               next_s.rdData[USD_DATA_W-1:0] = s.rxBuf;
               next_s.rxReady = 1'b0;
            end
            USD_ADDR_BAUD: begin
               next_s.rdData[USD_DIV_W-1:0] = s.baud_divisor;
            end
            default: begin
               next_s.rdData = '0;
            end
         endcase
      end

      // transmit: copy holding into shift register when idle
      if (txLoad) begin
         next_s.txShift = s.txHold;
         next_s.txPar = parityOf(s.txHold & (8'hFF >> (2'h3 - s.wordLen)), s.pmode);
         next_s.txHoldFull = 1'b0;
         next_s.txSt = TX_START;
         next_s.txTick = '0;
      end

      // register writes
      if (busReq.wr) begin
         case (busReq.addr)
            USD_ADDR_CTRL: begin
               next_s.loop = busReq.wdata[USD_CT_LOOP];
               next_s.brk = busReq.wdata[USD_CT_BRK];
               next_s.dsr = busReq.wdata[USD_CT_DSR];
               next_s.pmode = busReq.wdata[USD_CT_PMODE_LO +: 3];
               next_s.stop2 = busReq.wdata[USD_CT_STOP];
               next_s.wordLen = busReq.wdata[USD_CT_WLEN_LO +: 2];
               next_s.txMode = busReq.wdata[USD_CT_TX_MODE_LO +: 2];
               next_s.rx_status_irq_en = busReq.wdata[USD_CT_RX_STATUS_IRQ_EN];
               next_s.rxMode = busReq.wdata[USD_CT_RX_MODE_LO +: 2];
            end
            USD_ADDR_STATUS: begin
               // holding and ready flags are read-only here
               next_s.breakSeen = s.breakSeen & busReq.wdata[USD_ST_BREAK];
               next_s.frameErr = s.frameErr & busReq.wdata[USD_ST_FRAME];
               next_s.parityErr = s.parityErr & busReq.wdata[USD_ST_PARITY];
               next_s.overrunErr = s.overrunErr & busReq.wdata[USD_ST_OVERRUN];
            end
            USD_ADDR_TX_HOLDING: begin
               next_s.txHold = busReq.wdata[USD_DATA_W-1:0];
               next_s.txHoldFull = 1'b1;
            end
            USD_ADDR_BAUD: begin
               next_s.baud_divisor = busReq.wdata[USD_DIV_W-1:0];
            end
            default: begin
               next_s.baud_divisor = next_s.baud_divisor;
            end
         endcase
      end

      // transmit bit timing, one bit per 16 ticks
      if (s.tick && (s.txSt != TX_IDLE)) begin
         next_s.txTick = 4'(s.txTick + 1'b1);
         if (s.txTick == USD_TICK_LAST) begin
            case (s.txSt)
               TX_START: begin
                  next_s.txSt = TX_DATA;
                  next_s.txBit = '0;
               end
               TX_DATA: begin
                  next_s.txShift = s.txShift >> 1;
                  next_s.txBit = 3'(s.txBit + 1'b1);
                  if (s.txBit == lastBit(s.wordLen)) begin
                     next_s.txSt = s.pmode[2] ? TX_PARITY : TX_STOP1;
                  end
               end
               TX_PARITY: next_s.txSt = TX_STOP1;
               TX_STOP1: next_s.txSt = s.stop2 ? TX_STOP2 : TX_IDLE;
               default: next_s.txSt = TX_IDLE;
            endcase
         end
      end
      if (s.txMode == USD_MODE_OFF) begin
         next_s.txSt = TX_IDLE;
         next_s.txTick = '0;
         next_s.txBit = '0;
      end
      case (next_s.txSt)
         TX_START: next_s.txLineLow = 1'b1;
         TX_DATA: next_s.txLineLow = !next_s.txShift[0];
         TX_PARITY: next_s.txLineLow = !next_s.txPar;
         default: next_s.txLineLow = 1'b0;
      endcase
      if (s.brk) begin
         next_s.txLineLow = 1'b1;
      end

      // receive: sample at bit centres, shift frame while buffer is held
      if (s.tick) begin
         next_s.rxTick = 4'(s.rxTick + 1'b1);
         case (s.rxSt)
            RX_IDLE: begin
               next_s.rxTick = '0;
               if (!rxIn) begin
                  next_s.rxSt = RX_START;
               end
            end
            RX_START: begin
               if (s.rxTick == USD_TICK_HALF) begin
                  next_s.rxTick = '0;
                  next_s.rxBit = '0;
                  next_s.rxShift = '0;
                  next_s.rxSt = rxIn ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (s.rxTick == USD_TICK_LAST) begin
                  next_s.rxShift = {rxIn, s.rxShift[7:1]};
                  next_s.rxBit = 3'(s.rxBit + 1'b1);
                  next_s.rxParBit = 1'b0;
                  if (s.rxBit == lastBit(s.wordLen)) begin
                     next_s.rxSt = s.pmode[2] ? RX_PARITY : RX_STOP;
                  end
               end
            end
            RX_PARITY: begin
               if (s.rxTick == USD_TICK_LAST) begin
                  next_s.rxParBit = rxIn;
                  next_s.rxSt = RX_STOP;
               end
            end
            RX_STOP: begin
               if (s.rxTick == USD_TICK_LAST) begin
                  next_s.rxSt = RX_IDLE;
                  if (!rxIn && (s.rxShift == '0) && !s.rxParBit) begin
                     next_s.breakSeen = 1'b1;
                     next_s.rxSt = RX_BRKWAIT;
                  end else begin
                     next_s.rxBuf = justify(s.rxShift, s.wordLen);
                     next_s.rxReady = 1'b1;
                     if (s.rxReady && !rxBufRead) begin
                        next_s.overrunErr = 1'b1;
                     end
                     if (!rxIn) begin
                        next_s.frameErr = 1'b1;
                     end
                     if (s.pmode[2] &&
                         (s.rxParBit != parityOf(justify(s.rxShift, s.wordLen), s.pmode))) begin
                        next_s.parityErr = 1'b1;
                     end
                  end
               end
            end
            default: begin
               next_s.rxTick = '0;
               if (rxIn) begin
                  next_s.rxSt = RX_IDLE;
               end
            end
         endcase
      end
      if (s.rxMode == USD_MODE_OFF) begin
         next_s.rxSt = RX_IDLE;
         next_s.rxTick = '0;
         next_s.rxBit = '0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s <= USD_STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   logic stWrite;
   logic stRead;
   assign stWrite = busReq.wr && (busReq.addr == USD_ADDR_STATUS);
   assign stRead = busReq.rd && (busReq.addr == USD_ADDR_STATUS);
   logic rxStopEnd;
   assign rxStopEnd = s.tick && (s.rxSt == RX_STOP) && (s.rxTick == USD_TICK_LAST);

   AST_HOLD_CLEAR: assert property (
      busReq.wr && (busReq.addr == USD_ADDR_TX_HOLDING) |=> s.txHoldFull && !txIrq)
      else $error("holding write did not clear holding empty");
   AST_EMPTY_BUSY: assert property (
      stRead && (s.txSt != TX_IDLE) |=> !rdData[USD_ST_TX_EMPTY])
      else $error("tx empty reported while shifting");
   AST_HOLD_RO: assert property (
      stWrite && !txLoad |=> s.txHoldFull == $past(s.txHoldFull))
      else $error("status write altered holding empty");
   AST_TX_REQ: assert property (
      $fell(s.txHoldFull) && (s.txMode != USD_MODE_OFF) |-> txIrq || (txDmaReq != 2'h0))
      else $error("holding empty did not raise the selected request");
   AST_RX_CLEAR: assert property (
      rxBufRead && !(s.tick && s.rxSt == RX_STOP) |=> !s.rxReady)
      else $error("buffer read did not clear rx ready");
   AST_DTR: assert property (
      stRead |=> rdData[USD_ST_DTR] == $past(dtr))
      else $error("status dtr bit does not follow pin");
   AST_ERR_STICKY: assert property (
      s.frameErr && !(stWrite && !busReq.wdata[USD_ST_FRAME]) |=> s.frameErr)
      else $error("framing flag lost without a zero write");
   AST_STATUS_IRQ: assert property (
      !s.rx_status_irq_en |-> !rxStatusIrq)
      else $error("status interrupt without enable");
   AST_TX_OFF: assert property (
      (s.txMode == USD_MODE_OFF) && !s.brk && !$past(s.brk) ##1 (s.txMode == USD_MODE_OFF) |-> txd)
      else $error("disabled transmitter does not hold line high");
   AST_START_LOW: assert property (
      (s.txSt == TX_START) && !s.loop |-> !txd)
      else $error("start bit not low");
   AST_BAUD: assert property (
      s.tick && (s.baud_divisor == '0) && !busReq.wr |=> !s.tick ##1 s.tick)
      else $error("16x tick period wrong at divisor zero");
   AST_TX_LOAD: assert property (
      txLoad && !(busReq.wr && (busReq.addr == USD_ADDR_TX_HOLDING))
      |=> (s.txSt == TX_START) && !s.txHoldFull)
      else $error("holding word not moved to shift register");
   AST_STOP_HIGH: assert property (
      (s.txSt == TX_STOP1) && !s.brk && !$past(s.brk) && !s.loop |-> txd)
      else $error("stop bit not high");
   AST_RX_SET: assert property (
      rxStopEnd && rxIn |=> s.rxReady)
      else $error("completed frame did not set rx ready");
   AST_OVERRUN: assert property (
      rxStopEnd && rxIn && s.rxReady && !rxBufRead |=> s.overrunErr)
      else $error("overrun not flagged");
   AST_FRAME_SET: assert property (
      rxStopEnd && !rxIn && (s.rxShift != '0) |=> s.frameErr)
      else $error("low stop bit not flagged");
   AST_BREAK_SET: assert property (
      rxStopEnd && !rxIn && (s.rxShift == '0) && !s.rxParBit |=> s.breakSeen)
      else $error("break not flagged");
   AST_RX_OFF: assert property (
      (s.rxMode == USD_MODE_OFF) |=> (s.rxSt == RX_IDLE))
      else $error("disabled receiver not idle");

   COV_RX_FRAME: cover property ($rose(s.rxReady));
   COV_FRAME_ERR: cover property ($rose(s.frameErr));
   COV_TX_DONE: cover property ((s.txSt == TX_STOP1) ##1 (s.txSt == TX_IDLE));
   COV_OVERRUN: cover property ($rose(s.overrunErr));
   COV_BREAK: cover property ($rose(s.breakSeen));
endmodule

//--- common/usd_pkg.sv
// usd_pkg: register map, fields, encodings and state types of the serial port
package usd_pkg;

   localparam logic [31:0] USD_ADDR_CTRL = 32'h8000_0080;
   localparam logic [31:0] USD_ADDR_STATUS = 32'h8000_0084;
   localparam logic [31:0] USD_ADDR_TX_HOLDING = 32'h8000_0088;
   localparam logic [31:0] USD_ADDR_RX_BUFFER = 32'h8000_008C;
   localparam logic [31:0] USD_ADDR_BAUD = 32'h8000_0090;

   // status fields
   localparam int USD_ST_TX_EMPTY = 10;
   localparam int USD_ST_TX_HOLD_EMPTY = 9;
   localparam int USD_ST_RX_READY = 8;
   localparam int USD_ST_DTR = 4;
   localparam int USD_ST_BREAK = 3;
   localparam int USD_ST_FRAME = 2;
   localparam int USD_ST_PARITY = 1;
   localparam int USD_ST_OVERRUN = 0;

   // control fields
   localparam int USD_CT_LOOP = 26;
   localparam int USD_CT_BRK = 25;
   localparam int USD_CT_DSR = 24;
   localparam int USD_CT_PMODE_LO = 19;
   localparam int USD_CT_STOP = 18;
   localparam int USD_CT_WLEN_LO = 16;
   localparam int USD_CT_TX_MODE_LO = 8;
   localparam int USD_CT_RX_STATUS_IRQ_EN = 2;
   localparam int USD_CT_RX_MODE_LO = 0;

   localparam int USD_DIV_W = 16;
   localparam int USD_DATA_W = 8;

   // service modes, shared by transmit and receive
   localparam logic [1:0] USD_MODE_OFF = 2'h0;
   localparam logic [1:0] USD_MODE_IRQ = 2'h1;
   localparam logic [1:0] USD_MODE_DMA0 = 2'h2;
   localparam logic [1:0] USD_MODE_DMA1 = 2'h3;

   // parity modes
   localparam logic [2:0] USD_PAR_ODD = 3'h4;
   localparam logic [2:0] USD_PAR_EVEN = 3'h5;
   localparam logic [2:0] USD_PAR_ONE = 3'h6;
   localparam logic [2:0] USD_PAR_ZERO = 3'h7;

   // timing in 16x ticks
   localparam logic [3:0] USD_TICK_HALF = 4'h7;
   localparam logic [3:0] USD_TICK_LAST = 4'hF;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} usd_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BRKWAIT} usd_rx_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } usd_req_s;

   typedef struct packed {
      logic [1:0] txMode;
      logic [1:0] rxMode;
      logic rx_status_irq_en;
      logic [1:0] wordLen;
      logic stop2;
      logic [2:0] pmode;
      logic brk;
      logic loop;
      logic dsr;
      logic [USD_DIV_W-1:0] baud_divisor;
      logic [USD_DIV_W-1:0] divCnt;
      logic phase;
      logic tick;
      logic [7:0] txHold;
      logic txHoldFull;
      usd_tx_e txSt;
      logic [7:0] txShift;
      logic [3:0] txTick;
      logic [2:0] txBit;
      logic txPar;
      logic txLineLow;
      usd_rx_e rxSt;
      logic [7:0] rxShift;
      logic [3:0] rxTick;
      logic [2:0] rxBit;
      logic rxParBit;
      logic [7:0] rxBuf;
      logic rxReady;
      logic breakSeen;
      logic frameErr;
      logic parityErr;
      logic overrunErr;
      logic [31:0] rdData;
   } usd_state_s;

   // everything zero: modes disabled, holding empty, line high
   localparam usd_state_s USD_STATE_RESET = '0;

endpackage

//--- dv/usd_serial_peer.sv
// usd_serial_peer: line-side serial peer model
`timescale 1ns/1ps
module usd_serial_peer (
   input wire logic ref_clk,
   input wire logic txd,
   output logic rxd,
   input wire logic [3:0] wordBits,
   input wire logic [15:0] bitCycles
);
   import usd_pkg::*;
   logic [7:0] gotQ[$];
   logic [7:0] cap;
   logic frameBad;
   int k;
   initial begin
      rxd = 1'b1;
      frameBad = 1'b0;
   end
   task automatic sendBit(input logic b);
      rxd <= b;
      repeat (bitCycles) @(posedge ref_clk);
   endtask
   // par below zero: no parity bit
   task automatic sendFrame(input logic [7:0] d, input int par, input logic stopLvl);
      int i;
      @(posedge ref_clk);
      sendBit(1'b0);
      for (i = 0; i < wordBits; i++) sendBit(d[i]);
      if (par >= 0) sendBit(par[0]);
      sendBit(stopLvl);
      sendBit(1'b1);
   endtask
   // frame capture off the transmit line, centre sampled
   always begin
      @(negedge txd);
      repeat (bitCycles / 2) @(posedge ref_clk);
      if (txd !== 1'b0) frameBad = 1'b1;
      cap = 8'h00;
      for (k = 0; k < wordBits; k++) begin
         repeat (bitCycles) @(posedge ref_clk);
         cap[k] = txd;
      end
      repeat (bitCycles) @(posedge ref_clk);
      if (txd !== 1'b1) frameBad = 1'b1;
      gotQ.push_back(cap);
   end
endmodule

//--- dv/usd_uart_tb.sv
// usd_uart_tb: self-checking bench for the serial port
`timescale 1ns/1ps
module usd_uart_tb;
   import usd_pkg::*;
   localparam int LIMIT = 20000;
   logic ref_clk, rstn, rxd, txd, dtr, dsr, txIrq, rxIrq, rxStatusIrq;
   usd_req_s busReq;
   logic [31:0] rdData, st;
   logic [1:0] txDmaReq, rxDmaReq;
   logic [3:0] wordBits;
   logic [15:0] bitCycles;
   int fail_count, total_checks, cycles;

   usd_uart i_usd_uart (.ref_clk(ref_clk), .rstn(rstn), .busReq(busReq), .rdData(rdData),
      .rxd(rxd), .txd(txd), .dtr(dtr), .dsr(dsr), .txIrq(txIrq), .rxIrq(rxIrq),
      .rxStatusIrq(rxStatusIrq), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq));
   usd_serial_peer i_usd_serial_peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
      .wordBits(wordBits), .bitCycles(bitCycles));

   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         $display("mismatch at %0t: timeout", $time);
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge ref_clk);
      busReq.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge ref_clk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask
   task automatic waitSt(input int b, input logic v, input int maxPolls);
      int n;
      n = 0;
      rd(USD_ADDR_STATUS, st);
      while (st[b] !== v && n < maxPolls) begin
         rd(USD_ADDR_STATUS, st);
         n++;
      end
      chk(32'(st[b]), 32'(v), "status wait");
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] tm, rm, input logic rx_status_irq_en,
                                       input logic [1:0] wl, input logic [2:0] pm);
      ctl = 32'h0;
      ctl[USD_CT_TX_MODE_LO +: 2] = tm;
      ctl[USD_CT_RX_MODE_LO +: 2] = rm;
      ctl[USD_CT_RX_STATUS_IRQ_EN] = rx_status_irq_en;
      ctl[USD_CT_WLEN_LO +: 2] = wl;
      ctl[USD_CT_PMODE_LO +: 3] = pm;
   endfunction

   task automatic t_reset;
      rd(USD_ADDR_STATUS, st);
      chk(st & 32'h0000_070F, 32'h0000_0600, "status reset");
      rd(USD_ADDR_CTRL, st);
      chk(st & 32'h0000_0303, 32'h0, "modes reset");
      chk(32'({txIrq, rxIrq, txDmaReq, rxDmaReq}), 32'h0, "requests off");
      chk(32'(txd), 32'h1, "line idle");
      rd(32'h8000_0094, st);
      chk(st, 32'h0, "unmapped read");
   endtask
   task automatic t_dtr;
      @(posedge ref_clk);
      dtr <= 1'b1;
      rd(USD_ADDR_STATUS, st);
      chk(32'(st[USD_ST_DTR]), 32'h1, "dtr high");
      @(posedge ref_clk);
      dtr <= 1'b0;
      rd(USD_ADDR_STATUS, st);
      chk(32'(st[USD_ST_DTR]), 32'h0, "dtr low");
      wr(USD_ADDR_CTRL, 32'h1 << USD_CT_DSR);
      chk(32'(dsr), 32'h1, "dsr set");
      wr(USD_ADDR_CTRL, 32'h0);
      chk(32'(dsr), 32'h0, "dsr clear");
   endtask
   task automatic t_modes;
      int m;
      for (m = 0; m < 4; m++) begin
         wr(USD_ADDR_CTRL, ctl(m[1:0], 2'h0, 1'b0, 2'h3, 3'h0));
         chk(32'(txIrq), 32'(m == 1), "tx irq");
         chk(32'(txDmaReq), 32'({m == 3, m == 2}), "tx dma");
      end
   endtask
   task automatic t_tx;
      wordBits = 4'h8;
      wr(USD_ADDR_CTRL, ctl(USD_MODE_IRQ, 2'h0, 1'b0, 2'h3, 3'h0));
      wr(USD_ADDR_TX_HOLDING, 32'h0000_00A5);
      waitSt(USD_ST_TX_HOLD_EMPTY, 1'b1, 20);
      wr(USD_ADDR_TX_HOLDING, 32'h0000_003C);
      wr(USD_ADDR_STATUS, 32'h0000_07F0);
      rd(USD_ADDR_STATUS, st);
      chk(st & 32'h0000_0600, 32'h0, "holding full");
      chk(32'(txIrq), 32'h0, "tx irq full");
      waitSt(USD_ST_TX_EMPTY, 1'b1, 1000);
      chk(32'(i_usd_serial_peer.gotQ.size()), 32'h2, "tx count");
      chk(32'(i_usd_serial_peer.gotQ[0]), 32'h0000_00A5, "tx first");
      chk(32'(i_usd_serial_peer.gotQ[1]), 32'h0000_003C, "tx second");
      chk(32'(i_usd_serial_peer.frameBad), 32'h0, "tx framing");
      i_usd_serial_peer.gotQ.delete();
   endtask
   task automatic t_baud;
      int d, n;
      for (d = 2; d >= 0; d -= 2) begin
         wr(USD_ADDR_BAUD, 32'(d));
         rd(USD_ADDR_BAUD, st);
         chk(st, 32'(d), "divisor");
         bitCycles = 16'(32 * (d + 1));
         wr(USD_ADDR_TX_HOLDING, 32'h0000_00FF);
         n = 0;
         while (txd !== 1'b0 && n < 2000) begin
            @(posedge ref_clk);
            n++;
         end
         n = 0;
         while (txd === 1'b0 && n < 2000) begin
            @(posedge ref_clk);
            n++;
         end
         chk(32'(n), 32'(32 * (d + 1)), "bit length");
         waitSt(USD_ST_TX_EMPTY, 1'b1, 1000);
      end
      i_usd_serial_peer.gotQ.delete();
   endtask
   task automatic t_rx;
      logic [7:0] sent[3] = '{8'h5A, 8'hF3, 8'hC6};
      logic [7:0] expd[3] = '{8'h5A, 8'h13, 8'hC6};
      logic [1:0] wl[3] = '{2'h3, 2'h0, 2'h3};
      int i;
      for (i = 0; i < 3; i++) begin
         wordBits = (wl[i] == 2'h0) ? 4'h5 : 4'h8;
         wr(USD_ADDR_CTRL, ctl(2'h0, 2'(i + 1), 1'b0, wl[i], 3'h0));
         i_usd_serial_peer.sendFrame(sent[i], -1, 1'b1);
         waitSt(USD_ST_RX_READY, 1'b1, 50);
         chk(32'(rxIrq), 32'(i == 0), "rx irq");
         chk(32'(rxDmaReq), 32'({i == 2, i == 1}), "rx dma");
         rd(USD_ADDR_RX_BUFFER, st);
         chk(st, 32'(expd[i]), "rx data");
         rd(USD_ADDR_STATUS, st);
         chk(32'(st[USD_ST_RX_READY]), 32'h0, "rx ready clear");
      end
   endtask
   task automatic t_err;
      logic [7:0] dat[4] = '{8'h81, 8'h01, 8'h00, 8'h00};
      int par[4] = '{-1, 0, -1, -1};
      logic stp[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
      int bix[4] = '{USD_ST_FRAME, USD_ST_PARITY, USD_ST_BREAK, USD_ST_BREAK};
      logic [2:0] pm[4] = '{3'h0, USD_PAR_EVEN, 3'h0, 3'h0};
      int e;
      wordBits = 4'h8;
      wr(USD_ADDR_CTRL, ctl(2'h0, USD_MODE_IRQ, 1'b1, 2'h3, 3'h0));
      i_usd_serial_peer.sendFrame(8'h11, -1, 1'b1);
      i_usd_serial_peer.sendFrame(8'h22, -1, 1'b1);
      waitSt(USD_ST_OVERRUN, 1'b1, 50);
      chk(32'(rxStatusIrq), 32'h1, "status irq");
      rd(USD_ADDR_RX_BUFFER, st);
      chk(st, 32'h0000_0022, "newest frame");
      wr(USD_ADDR_STATUS, 32'h0000_000F);
      rd(USD_ADDR_STATUS, st);
      chk(32'(st[USD_ST_OVERRUN]), 32'h1, "one keeps flag");
      wr(USD_ADDR_STATUS, 32'h0);
      rd(USD_ADDR_STATUS, st);
      chk(st & 32'h0000_000F, 32'h0, "zero clears");
      chk(32'(rxStatusIrq), 32'h0, "status irq off");
      for (e = 0; e < 4; e++) begin
         wr(USD_ADDR_CTRL, ctl(2'h0, USD_MODE_IRQ, e != 3, 2'h3, pm[e]));
         i_usd_serial_peer.sendFrame(dat[e], par[e], stp[e]);
         rd(USD_ADDR_STATUS, st);
         chk(32'(st[bix[e]]), 32'h1, "error flag");
         chk(32'(rxStatusIrq), 32'(e != 3), "status irq");
         if (e < 2) begin
            rd(USD_ADDR_RX_BUFFER, st);
         end
         wr(USD_ADDR_STATUS, 32'h0);
      end
   endtask
   task automatic t_loop;
      wr(USD_ADDR_CTRL, ctl(USD_MODE_IRQ, USD_MODE_IRQ, 1'b1, 2'h3, USD_PAR_ODD)
         | (32'h1 << USD_CT_LOOP) | (32'h1 << USD_CT_STOP));
      wr(USD_ADDR_TX_HOLDING, 32'h0000_0096);
      waitSt(USD_ST_RX_READY, 1'b1, 400);
      chk(32'(txd), 32'h1, "loop line high");
      rd(USD_ADDR_RX_BUFFER, st);
      chk(st, 32'h0000_0096, "loop data");
      rd(USD_ADDR_STATUS, st);
      chk(st & 32'h0000_000F, 32'h0, "loop no error");
      waitSt(USD_ST_TX_EMPTY, 1'b1, 100);
   endtask
   task automatic t_txoff;
      int n;
      wr(USD_ADDR_CTRL, ctl(USD_MODE_IRQ, 2'h0, 1'b0, 2'h3, 3'h0));
      wr(USD_ADDR_TX_HOLDING, 32'h0);
      n = 0;
      while (txd !== 1'b0 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      wr(USD_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge ref_clk);
      n = 0;
      repeat (40) begin
         @(posedge ref_clk);
         if (txd !== 1'b1) n++;
      end
      chk(32'(n), 32'h0, "tx off line high");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      busReq = '0;
      dtr = 1'b0;
      wordBits = 4'h8;
      bitCycles = 16'h0020;
      fail_count = 0;
      total_checks = 0;
      cycles = 0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset();
      t_dtr();
      t_modes();
      t_tx();
      t_baud();
      t_rx();
      t_err();
      t_loop();
      t_txoff();
      results();
   end
endmodule
